// ---- logic/rbm_reset_boot.sv ----
// reset qualification, reset-out stretching and boot clock mode selection
//
// Summary of operation
// R1: reset input held low eight cpu clocks resets cpu and peripherals at once.
// R2: reset-out stays low 1024 cpu clocks after every reset source goes away.
// R3: mode 00 disables pll; crystal pin 0 external clock, 1 on-chip oscillator.
// R4: mode 01 disables pll and runs from the crystal, crystal pin ignored.
// R5: mode 10 runs pll; reference external clock or on-chip oscillator by crystal pin.
// R6: mode 11 runs pll from the crystal, crystal pin ignored.
// R7: config pin low with test pin low at reset exit enters flash programming.
// R8: in flash programming mode the serial programming port owns the flash.
// R9: clock-out follows the selected internal system clock.
// R10: straps are sampled at reset exit and held until the next reset.
`timescale 1ns/1ps
module rbm_reset_boot (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// board reset and other reset sources
	input wire logic reset_in_n,
	input wire logic other_reset,
	// straps
	input wire logic [1:0] clock_mode_sel,
	input wire logic crystal_pin,
	input wire logic reset_config_n,
	input wire logic test_pin,
	// internal system clock selected by the clock generator
	input wire logic sys_clock_sel,
	// resets
	output logic core_reset,
	output logic reset_out_n,
	// clock selection
	output logic pll_enable,
	output rbm_pkg::rbm_src_t clock_source,
	output logic system_clock_out,
	// flash programming
	output logic flash_prog_mode,
	output logic flash_port_grant
);
	localparam logic [3:0] QUAL_MAX = 4'(rbm_pkg::RST_QUAL_CYCLES - 1);
	localparam logic [rbm_pkg::RST_OUT_W-1:0] OUT_MAX =
		rbm_pkg::RST_OUT_W'(rbm_pkg::RST_OUT_CYCLES - 1);

	logic [3:0] qual_cnt;
	logic [3:0] next_qual_cnt;
	logic qual_reset;
	logic next_core_reset;
	logic next_reset_out_n;
	logic next_pll_enable;
	rbm_pkg::rbm_src_t next_clock_source;
	logic next_flash_prog_mode;
	logic next_flash_port_grant;
	logic next_system_clock_out;
	rbm_pkg::rbm_state_t state;
	rbm_pkg::rbm_state_t next_state;
	logic any_reset;
	logic [rbm_pkg::RST_OUT_W-1:0] stretch_cnt;

	// low-input qualifier; glitches shorter than eight clocks are filtered out
	always_comb begin
		next_qual_cnt = '0;
		if (!reset_in_n) begin
			next_qual_cnt = (qual_cnt == QUAL_MAX) ? qual_cnt : qual_cnt + 4'h1;
		end
	end
	assign qual_reset = !reset_in_n && (qual_cnt == QUAL_MAX); // [R1]
	assign any_reset = qual_reset || other_reset || srst;

	always_ff @(posedge clk) begin
		if (srst) begin
			qual_cnt <= 4'h0;
		end else begin
			qual_cnt <= next_qual_cnt;
		end
	end

	// stretch counter runs only after every source has gone away
	rbm_counter #(
		.W(rbm_pkg::RST_OUT_W)
	) u_stretch (
		.clk(clk),
		.clear(any_reset || (state != rbm_pkg::RBM_ST_STRETCH)),
		.enable(state == rbm_pkg::RBM_ST_STRETCH),
		.count(stretch_cnt)
	);

	// sequencer and strap decode
	always_comb begin
		next_state = state;
		next_core_reset = core_reset;
		next_reset_out_n = reset_out_n;
		next_pll_enable = pll_enable;
		next_clock_source = clock_source;
		next_flash_prog_mode = flash_prog_mode;
		case (state)
			rbm_pkg::RBM_ST_RESET: begin
				next_core_reset = 1'b1;
				next_reset_out_n = 1'b0;
				if (!any_reset) begin
					// straps sampled as the core leaves reset [R10]
					next_state = rbm_pkg::RBM_ST_STRETCH;
					next_core_reset = 1'b0;
					case (clock_mode_sel)
						rbm_pkg::MODE_NOPLL_PIN: begin
							next_pll_enable = 1'b0; // [R3]
							next_clock_source = crystal_pin ? rbm_pkg::RBM_SRC_OSC :
								rbm_pkg::RBM_SRC_EXT;
						end
						rbm_pkg::MODE_NOPLL_CRYSTAL_PIN: begin
							next_pll_enable = 1'b0; // [R4]
							next_clock_source = rbm_pkg::RBM_SRC_CRYSTAL_PIN;
						end
						rbm_pkg::MODE_PLL_PIN: begin
							next_pll_enable = 1'b1; // [R5]
							next_clock_source = crystal_pin ? rbm_pkg::RBM_SRC_OSC :
								rbm_pkg::RBM_SRC_EXT;
						end
						default: begin
							next_pll_enable = 1'b1; // [R6]
							next_clock_source = rbm_pkg::RBM_SRC_CRYSTAL_PIN;
						end
					endcase
					next_flash_prog_mode = !reset_config_n && !test_pin; // [R7]
				end
			end
			rbm_pkg::RBM_ST_STRETCH: begin
				if (stretch_cnt == OUT_MAX) begin
					next_state = rbm_pkg::RBM_ST_RUN;
					next_reset_out_n = 1'b1; // [R2]
				end
			end
			default: begin
				next_reset_out_n = 1'b1;
			end
		endcase
		// any source returns to reset at once, from any state [R1]
		if (any_reset) begin
			next_state = rbm_pkg::RBM_ST_RESET;
			next_core_reset = 1'b1;
			next_reset_out_n = 1'b0;
		end
		// port grant only while the core is out of reset
		next_flash_port_grant = next_flash_prog_mode && !next_core_reset; // [R8]
		next_system_clock_out = sys_clock_sel; // [R9]
	end

	// selections stay put until the next reset
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= rbm_pkg::RBM_ST_RESET;
			core_reset <= 1'b1;
			reset_out_n <= 1'b0;
			pll_enable <= 1'b0;
			clock_source <= rbm_pkg::RBM_SRC_EXT;
			flash_prog_mode <= 1'b0;
			flash_port_grant <= 1'b0;
			system_clock_out <= 1'b0;
		end else begin
			state <= next_state;
			core_reset <= next_core_reset;
			reset_out_n <= next_reset_out_n;
			pll_enable <= next_pll_enable;
			clock_source <= next_clock_source;
			flash_prog_mode <= next_flash_prog_mode;
			flash_port_grant <= next_flash_port_grant;
			system_clock_out <= next_system_clock_out;
		end
	end

	// assertions
	property p_qual_reset;
		@(posedge clk) disable iff (srst)
		(!reset_in_n) [*8] |=> core_reset;
	endproperty
	a_qual_reset: assert property (p_qual_reset) else $error("reset not taken"); // [R1]

	property p_short_glitch;
		@(posedge clk) disable iff (srst)
		$rose(reset_in_n) && !other_reset && $past(qual_cnt) < QUAL_MAX
			&& state == rbm_pkg::RBM_ST_RUN |-> !core_reset;
	endproperty
	a_short_glitch: assert property (p_short_glitch) else $error("glitch reset core"); // [R1]

	property p_out_low;
		@(posedge clk) disable iff (srst || any_reset)
		$fell(core_reset) |-> !reset_out_n [*8];
	endproperty
	a_out_low: assert property (p_out_low) else $error("reset-out early"); // [R2]

	property p_out_release;
		@(posedge clk) disable iff (srst)
		$rose(reset_out_n) |-> $past(stretch_cnt) == OUT_MAX;
	endproperty
	a_out_release: assert property (p_out_release) else $error("reset-out length"); // [R2]

	property p_mode00;
		@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RESET && !any_reset && clock_mode_sel == 2'h0
			|=> !pll_enable && clock_source == ($past(crystal_pin) ?
			rbm_pkg::RBM_SRC_OSC : rbm_pkg::RBM_SRC_EXT);
	endproperty
	a_mode00: assert property (p_mode00) else $error("mode 00 decode"); // [R3]

	property p_mode01;
		@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RESET && !any_reset && clock_mode_sel == 2'h1
			|=> !pll_enable && clock_source == rbm_pkg::RBM_SRC_CRYSTAL_PIN;
	endproperty
	a_mode01: assert property (p_mode01) else $error("mode 01 decode"); // [R4]

	property p_mode10;
		@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RESET && !any_reset && clock_mode_sel == 2'h2
			|=> pll_enable && clock_source == ($past(crystal_pin) ?
			rbm_pkg::RBM_SRC_OSC : rbm_pkg::RBM_SRC_EXT);
	endproperty
	a_mode10: assert property (p_mode10) else $error("mode 10 decode"); // [R5]

	property p_mode11;
		@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RESET && !any_reset && clock_mode_sel == 2'h3
			|=> pll_enable && clock_source == rbm_pkg::RBM_SRC_CRYSTAL_PIN;
	endproperty
	a_mode11: assert property (p_mode11) else $error("mode 11 decode"); // [R6]

	property p_prog_entry;
		@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RESET && !any_reset
			|=> flash_prog_mode == (!$past(reset_config_n) && !$past(test_pin));
	endproperty
	a_prog_entry: assert property (p_prog_entry) else $error("prog mode entry"); // [R7]

	property p_grant;
		@(posedge clk) disable iff (srst)
		flash_port_grant |-> flash_prog_mode && !core_reset;
	endproperty
	a_grant: assert property (p_grant) else $error("grant outside mode"); // [R8]

	property p_system_clock_out;
		@(posedge clk) disable iff (srst)
		// the edge that releases srst still loads the reset value, so skip it
		!srst |=> system_clock_out == $past(sys_clock_sel);
	endproperty
	a_system_clock_out: assert property (p_system_clock_out) else $error("clock-out mismatch"); // [R9]

	property p_hold;
		@(posedge clk) disable iff (srst)
		state != rbm_pkg::RBM_ST_RESET && !any_reset
			|=> $stable(pll_enable) && $stable(clock_source) && $stable(flash_prog_mode);
	endproperty
	a_hold: assert property (p_hold) else $error("selection changed"); // [R10]

	c_run: cover property (@(posedge clk) disable iff (srst) $rose(reset_out_n));
	c_prog: cover property (@(posedge clk) disable iff (srst) $rose(flash_port_grant));
	c_pll: cover property (@(posedge clk) disable iff (srst) $rose(pll_enable));
	c_rerst: cover property (@(posedge clk) disable iff (srst)
		state == rbm_pkg::RBM_ST_RUN ##1 core_reset);
endmodule : rbm_reset_boot

// ---- logic/rbm_pkg.sv ----
// package of constants and types for the reset and boot mode selector
package rbm_pkg;
	// reset input qualification length in cpu clocks
	localparam int RST_QUAL_CYCLES = 8;
	// reset-out stretch after the last reset source goes away, in cpu clocks
	localparam int RST_OUT_CYCLES = 1024;
	localparam int RST_OUT_W = 11;
	// clock mode pin encodings
	localparam logic [1:0] MODE_NOPLL_PIN = 2'h0;
	localparam logic [1:0] MODE_NOPLL_CRYSTAL_PIN = 2'h1;
	localparam logic [1:0] MODE_PLL_PIN = 2'h2;
	localparam logic [1:0] MODE_PLL_CRYSTAL_PIN = 2'h3;
	// clock source selection codes
	typedef enum logic [1:0] {
		RBM_SRC_EXT = 2'h0,
		RBM_SRC_OSC = 2'h1,
		RBM_SRC_CRYSTAL_PIN = 2'h2
	} rbm_src_t;
	// sequencer states
	typedef enum logic [1:0] {
		RBM_ST_RESET = 2'h0,
		RBM_ST_STRETCH = 2'h1,
		RBM_ST_RUN = 2'h2
	} rbm_state_t;
endpackage : rbm_pkg

// ---- logic/rbm_counter.sv ----
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
module rbm_counter #(
	parameter int W = 11
) (
	// clock and control
	input wire logic clk,
	input wire logic clear,
	input wire logic enable,
	// count value
	output logic [W-1:0] count
);
	logic [W-1:0] next_count;

	// stops at all ones so a long hold never wraps back to a short count
	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (enable && (count != {W{1'b1}})) begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		count <= next_count;
	end
endmodule : rbm_counter

// ---- verif/rbm_board_model.sv ----
// board reset circuit and strap model facing the reset and boot selector
`timescale 1ns/1ps
module rbm_board_model (
	// clock
	input wire logic clk,
	// bench requests
	input wire logic hold_rst,
	input wire logic [4:0] strap_req,
	// board pins
	output logic reset_in_n,
	output logic [1:0] clock_mode_sel,
	output logic crystal_pin,
	output logic reset_config_n,
	output logic test_pin,
	output logic sys_clock_sel
);
	logic phase = 1'b0;
	// reset button straight onto the pin, pull-up gives high when released
	assign reset_in_n = ~hold_rst;
	// straps registered so they stay steady across the reset exit
	always @(posedge clk) begin
		{clock_mode_sel, crystal_pin, reset_config_n, test_pin} <= strap_req;
		phase <= ~phase;
	end
	// internal clock level flips every cycle, the worst case for a mirror
	assign sys_clock_sel = phase;
endmodule : rbm_board_model

// ---- verif/tb_reset_and_boot_mode_select.sv ----
// self-checking bench for the reset and boot selector
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_reset_and_boot_mode_select;
	logic clk = 1'b0, srst = 1'b1, hold = 1'b0, other = 1'b0;
	logic [4:0] strap = 5'h00;
	logic [4:0] s_cur;
	logic [15:0] lfsr = 16'h0001;
	int mismatches = 0, compares = 0, cycles = 0;
	logic reset_in_n, crystal_pin, reset_config_n, test_pin, sys_clock_sel, prev;
	logic [1:0] clock_mode_sel;
	logic core_reset, reset_out_n, pll_enable, system_clock_out, prog, grant;
	rbm_pkg::rbm_src_t clock_source;
	rbm_board_model board (.clk(clk), .hold_rst(hold), .strap_req(strap),
		.reset_in_n(reset_in_n), .clock_mode_sel(clock_mode_sel), .crystal_pin(crystal_pin),
		.reset_config_n(reset_config_n), .test_pin(test_pin), .sys_clock_sel(sys_clock_sel));
	rbm_reset_boot DUT (.clk(clk), .srst(srst), .reset_in_n(reset_in_n), .other_reset(other),
		.clock_mode_sel(clock_mode_sel), .crystal_pin(crystal_pin),
		.reset_config_n(reset_config_n), .test_pin(test_pin), .sys_clock_sel(sys_clock_sel),
		.core_reset(core_reset), .reset_out_n(reset_out_n), .pll_enable(pll_enable),
		.clock_source(clock_source), .system_clock_out(system_clock_out),
		.flash_prog_mode(prog), .flash_port_grant(grant));
	// 100 ns period
	always #50 clk = ~clk;
	// hang guard, a full run needs about 9400 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	function automatic rbm_pkg::rbm_src_t exp_src(input logic [1:0] m, input logic x);
		if (m[0])
			return rbm_pkg::RBM_SRC_CRYSTAL_PIN;
		return x ? rbm_pkg::RBM_SRC_OSC : rbm_pkg::RBM_SRC_EXT;
	endfunction : exp_src
	task automatic check_decode(input logic [4:0] s);
		`CHK("pll_enable", s[4], pll_enable)
		`CHK("clock_source", exp_src(s[4:3], s[2]), clock_source)
		`CHK("flash_prog_mode", ~s[1] & ~s[0], prog)
		`CHK("flash_port_grant", ~s[1] & ~s[0], grant)
	endtask : check_decode
	// waits for core reset to drop, checks the decode, then times reset-out
	task automatic exit_reset(input logic [4:0] s);
		int n;
		n = 0;
		while (core_reset !== 1'b0 && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		check_decode(s);
		n = 0;
		while (reset_out_n !== 1'b1 && n < 1100) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK("reset_out_stretch", 1024, n)
	endtask : exit_reset
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		#1 exit_reset(strap);
		// every mode and crystal level, random config and test straps
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			// xor with the index so the test strap is driven high as well
			s_cur = {i[2:0], (i == 2) ? 2'h0 : (lfsr[1:0] ^ i[1:0])};
			strap <= s_cur;
			@(posedge clk);
			if (i == 3) begin
				other <= 1'b1;
				repeat (3) @(posedge clk);
				other <= 1'b0;
			end else begin
				// the eighth low sample itself takes the core into reset
				hold <= 1'b1;
				repeat (7) @(posedge clk);
				#1 `CHK("core_reset_early", 1'b0, core_reset)
				@(posedge clk);
				hold <= 1'b0;
				#1 `CHK("core_reset_at_8", 1'b1, core_reset)
				`CHK("reset_out_in_reset", 1'b0, reset_out_n)
				`CHK("grant_in_reset", 1'b0, grant)
			end
			exit_reset(s_cur);
			// straps moved after exit must not alter the selection
			strap <= ~strap;
			repeat (3) @(posedge clk);
			#1 check_decode(~strap);
			$display("test boot %0d done", i);
		end
		// seven low samples are not a reset
		@(posedge clk);
		hold <= 1'b1;
		repeat (7) @(posedge clk);
		hold <= 1'b0;
		repeat (4) @(posedge clk);
		#1 `CHK("core_reset_short", 1'b0, core_reset)
		$display("test short pulse done");
		// clock-out mirrors the selected internal clock one cycle late
		for (int k = 0; k < 6; k++) begin
			prev = sys_clock_sel;
			@(posedge clk);
			#1 `CHK("system_clock_out", prev, system_clock_out)
		end
		$display("test clock out done");
		print_verdict();
	end
endmodule : tb_reset_and_boot_mode_select
